// >>> dv/pdm_cpu_model.sv
// partner model: cpu issuing sleep and interrupt sources holding requests
`timescale 1ns/1ps
module pdm_cpu_model import pdm_pkg::*; (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic go_sleep,
  input wire pdm_wake_t raise,
  input wire logic wake_ack,
  output logic sleep_exec,
  output pdm_wake_t wake_req
);
  // requests stay pending until handling starts, as a real request flag does
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_exec <= 1'b0;
      wake_req <= '0;
    end else begin
      sleep_exec <= go_sleep;
      wake_req <= wake_ack ? raise : (wake_req | raise);
    end
  end
endmodule

// >>> dv/pdm_power_ctrl_tb.sv
// testbench for the power-down mode controller
`timescale 1ns/1ps
module pdm_power_ctrl_tb;
  import pdm_pkg::*;
  typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] r; logic [1:0] dv; logic d4;} pdm_reg_row_t;
  typedef struct {logic [7:0] a; logic [7:0] b; logic tma; pdm_mode_t m; logic halt; logic osc; logic pwm;} pdm_mode_row_t;
  logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, tma = 0, int_mask = 0, go_sleep = 0, reset_in_n = 1;
  logic [15:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, reg_rdata, d;
  logic sleep_exec, cpu_halt, cpu_reset, cpu_clk_sub, sys_osc_en, watch_sample_div4, periph_run, pwm_run;
  logic ext_irq_capture, wake_ack, acked = 0;
  logic [1:0] sub_clock_div;
  pdm_wake_t wake_req, wake_en = '1, raise = '0;
  pdm_mode_t mode;
  int n_errors = 0, cmp_count = 0, cycles = 0, settle_n = 0;
  pdm_reg_row_t rr[6] = '{'{16'hFFF0, 8'h00, 8'h07, 2'h0, 1'b0}, '{16'hFFF0, 8'hFF, 8'hFF, 2'h0, 1'b0},
    '{16'hFFF1, 8'h1F, 8'hFF, 2'h3, 1'b1}, '{16'hFFF1, 8'h00, 8'hE0, 2'h0, 1'b0},
    '{16'hFFF1, 8'h11, 8'hF1, 2'h1, 1'b1}, '{16'hFFF2, 8'hFF, 8'h00, 2'h1, 1'b1}};
  pdm_mode_row_t mr[5] = '{'{8'h00, 8'hE0, 1'b0, PDM_SLEEP, 1'b1, 1'b1, 1'b0},
    '{8'h80, 8'hE0, 1'b0, PDM_STANDBY, 1'b1, 1'b0, 1'b0}, '{8'h80, 8'hE0, 1'b1, PDM_WATCH, 1'b1, 1'b0, 1'b0},
    '{8'h00, 8'hEC, 1'b0, PDM_ACT_MED, 1'b0, 1'b1, 1'b1}, '{8'h88, 8'hE8, 1'b1, PDM_SUBACT, 1'b0, 1'b0, 1'b0}};

  pdm_power_ctrl #(.WAIT_BASE(4)) dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_exec(sleep_exec),
    .timer_a_watch_select(tma), .int_mask(int_mask), .wake_req(wake_req), .wake_en(wake_en),
    .reset_in_n(reset_in_n), .mode(mode), .cpu_halt(cpu_halt), .cpu_reset(cpu_reset), .cpu_clk_sub(cpu_clk_sub),
    .sys_osc_en(sys_osc_en), .sub_clock_div(sub_clock_div), .watch_sample_div4(watch_sample_div4),
    .periph_run(periph_run), .pwm_run(pwm_run), .ext_irq_capture(ext_irq_capture), .wake_ack(wake_ack));
  pdm_cpu_model cpu (.core_clk(core_clk), .sys_rst(sys_rst), .go_sleep(go_sleep), .raise(raise),
    .wake_ack(wake_ack), .sleep_exec(sleep_exec), .wake_req(wake_req));

  initial begin
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (wake_ack === 1'b1) acked = 1;
    if (mode === PDM_SETTLE) settle_n++;
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] w);
    @(posedge core_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= w;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(logic [15:0] a);
    @(posedge core_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    sys_rst <= 1;
    tma <= 0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 0;
  endtask
  task automatic sleep();
    @(posedge core_clk);
    go_sleep <= 1;
    @(posedge core_clk);
    go_sleep <= 0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic ask(pdm_wake_t w);
    @(posedge core_clk);
    raise <= w;
    @(posedge core_clk);
    raise <= '0;
  endtask
  // bounded wait so a stuck controller ends in a mismatch, not a hang
  task automatic wait_mode(pdm_mode_t m, int lim);
    for (int i = 0; i < lim && mode !== m; i++) @(posedge core_clk);
    @(posedge core_clk);
    #1;
  endtask

  initial begin
    do_reset();
    rd(16'hFFF0);
    chk("ctrl_a reset", d, 8'h07);
    chk("cpu reset off", {7'h0, cpu_reset}, 8'h00);
    rd(16'hFFF1);
    chk("ctrl_b reset", d, 8'hE0);
    foreach (rr[i]) begin
      wr(rr[i].a, rr[i].w);
      rd(rr[i].a);
      chk("read back", d, rr[i].r);
      chk("sub div", {6'h0, sub_clock_div}, {6'h0, rr[i].dv});
      chk("sample div4", {7'h0, watch_sample_div4}, {7'h0, rr[i].d4});
    end
    foreach (mr[i]) begin
      do_reset();
      wr(16'hFFF0, mr[i].a);
      wr(16'hFFF1, mr[i].b);
      tma <= mr[i].tma;
      sleep();
      chk("mode", {5'h0, mode}, {5'h0, mr[i].m});
      chk("halt", {7'h0, cpu_halt}, {7'h0, mr[i].halt});
      chk("osc", {7'h0, sys_osc_en}, {7'h0, mr[i].osc});
      chk("pwm", {7'h0, pwm_run}, {7'h0, mr[i].pwm});
    end
    // masked wake first, then the same request let through
    do_reset();
    sleep();
    chk("periph in sleep", {7'h0, periph_run}, 8'h01);
    int_mask <= 1;
    ask('{timer_a: 0, ext_base: 0, ext_other: 0, periph: 1});
    repeat (10) @(posedge core_clk);
    #1 chk("masked", {5'h0, mode}, {5'h0, PDM_SLEEP});
    int_mask <= 0;
    wake_en <= '{timer_a: 1, ext_base: 1, ext_other: 1, periph: 0};
    repeat (5) @(posedge core_clk);
    #1 chk("disabled", {5'h0, mode}, {5'h0, PDM_SLEEP});
    acked = 0;
    wake_en <= '1;
    wait_mode(PDM_ACT_HI, 10);
    chk("sleep wake", {5'h0, mode}, {5'h0, PDM_ACT_HI});
    chk("ack", {7'h0, acked}, 8'h01);
    for (int s = 0; s < 5; s++) begin
      do_reset();
      wr(16'hFFF0, 8'h80 | (s[7:0] << 4));
      wr(16'hFFF1, 8'hE4);
      sleep();
      ask('{timer_a: 0, ext_base: 0, ext_other: 1, periph: 1});
      repeat (5) @(posedge core_clk);
      #1 chk("retained", {5'h0, mode}, {5'h0, PDM_STANDBY});
      chk("capture off", {7'h0, ext_irq_capture}, 8'h00);
      settle_n = 0;
      ask('{timer_a: 0, ext_base: 1, ext_other: 0, periph: 0});
      wait_mode(PDM_ACT_MED, 200);
      chk("settle len", settle_n[7:0], 8'(4 << s));
      chk("resume med", {5'h0, mode}, {5'h0, PDM_ACT_MED});
    end
    do_reset();
    wr(16'hFFF0, 8'h80);
    tma <= 1;
    sleep();
    chk("watch", {5'h0, mode}, {5'h0, PDM_WATCH});
    ask('{timer_a: 1, ext_base: 0, ext_other: 0, periph: 0});
    wait_mode(PDM_ACT_HI, 20);
    chk("watch to active", {5'h0, mode}, {5'h0, PDM_ACT_HI});
    chk("system clock", {7'h0, cpu_clk_sub}, 8'h00);
    do_reset();
    wr(16'hFFF0, 8'h88);
    tma <= 1;
    sleep();
    ask('{timer_a: 1, ext_base: 0, ext_other: 0, periph: 0});
    wait_mode(PDM_SUBACT, 10);
    chk("sub clock", {7'h0, cpu_clk_sub}, 8'h01);
    wr(16'hFFF1, 8'hEA);
    rd(16'hFFF1);
    chk("div frozen", d, 8'hE8);
    chk("div out", {6'h0, sub_clock_div}, 8'h00);
    wr(16'hFFF0, 8'h80);
    sleep();
    wait_mode(PDM_ACT_HI, 20);
    chk("direct up", {5'h0, mode}, {5'h0, PDM_ACT_HI});
    wr(16'hFFF0, 8'h88);
    sleep();
    wr(16'hFFF0, 8'h08);
    sleep();
    chk("subsleep", {5'h0, mode}, {5'h0, PDM_SUBSLEEP});
    ask('{timer_a: 1, ext_base: 0, ext_other: 0, periph: 0});
    wait_mode(PDM_SUBACT, 10);
    chk("subsleep wake", {5'h0, mode}, {5'h0, PDM_SUBACT});
    reset_in_n <= 0;
    wait_mode(PDM_ACT_HI, 20);
    chk("pin reset", {7'h0, cpu_reset}, 8'h01);
    chk("pin mode", {5'h0, mode}, {5'h0, PDM_ACT_HI});
    reset_in_n <= 1;
    wrap_up();
  end
endmodule

// >>> rtl/pdm_power_ctrl.sv
// power-down mode controller: control registers, sleep decode, settling wait, clock selects
`timescale 1ns/1ps
`include "pdm_defs.svh"

// Notes on behaviour
// - standby_select 0: sleep or subsleep
// - standby_select 1: standby/watch, or watch
// - wake wait 8192 shifted by code
// - low_speed_select picks clock after watch
// - reserved bits read one, ignore writes
// - sample rate bit: div16 or div4
// - no direct transfer: ordinary power-down entry
// - direct from high speed: medium or subactive
// - direct from medium: high or subactive
// - direct from subactive to high/medium
// - medium_speed_select picks resumed active speed
// - sub divider 8, 4 or 2
// - sub divider frozen while subactive
// - sleep halts cpu, peripherals except pwm run
// - permitted interrupt ends sleep, starts handling
// - mask flag or disabled source blocks wake
// - reset pin low resets cpu, ends sleep
// - retained external interrupts ignored, flags kept
// - control registers at FFF0 and FFF1
// - watch needs timer_a_watch_select; standby not
module pdm_power_ctrl import pdm_pkg::*; #(
  parameter int unsigned WAIT_BASE = `PDM_WAIT_BASE_STATES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep_exec,
  input wire logic timer_a_watch_select,
  input wire logic int_mask,
  input wire pdm_wake_t wake_req,
  input wire pdm_wake_t wake_en,
  input wire logic reset_in_n,
  output pdm_mode_t mode,
  output logic cpu_halt,
  output logic cpu_reset,
  output logic cpu_clk_sub,
  output logic sys_osc_en,
  output logic [1:0] sub_clock_div,
  output logic watch_sample_div4,
  output logic periph_run,
  output logic pwm_run,
  output logic ext_irq_capture,
  output logic wake_ack
);

  localparam int W = `PDM_WAIT_CNT_W;

  logic [7:3] ctrl_a_q;
  logic [4:0] ctrl_b_q;
  pdm_mode_t mode_q, mode_d;
  logic [W-1:0] settle_cnt_q;
  logic [2:0] pin_sync_q;
  logic pin_n_q;
  logic [7:0] rdata_q;
  logic halt_q, rst_out_q, clk_sub_q, osc_q, div4_q, prun_q, pwm_q, capt_q, ack_q, ack_d;
  logic [1:0] sdiv_q;

  // field views
  wire standby_select = ctrl_a_q[`PDM_A_STANDBY_SEL];
  wire [2:0] wake_wait_sel = ctrl_a_q[`PDM_A_WAIT_SEL_HI:`PDM_A_WAIT_SEL_LO];
  wire low_speed_select = ctrl_a_q[`PDM_A_LOW_SPEED];
  wire watch_sample_rate_sel = ctrl_b_q[`PDM_B_SAMPLE_RATE];
  wire direct_transfer_enable = ctrl_b_q[`PDM_B_DIRECT];
  wire medium_speed_select = ctrl_b_q[`PDM_B_MEDIUM];
  wire [1:0] sub_div_field = ctrl_b_q[`PDM_B_SUB_DIV_HI:`PDM_B_SUB_DIV_LO];

  // register decode
  wire sel_a = reg_addr == `PDM_ADDR_CTRL_A;
  wire sel_b = reg_addr == `PDM_ADDR_CTRL_B;
  wire wr_a = reg_wr && sel_a;
  wire wr_b = reg_wr && sel_b;
  wire [7:0] read_a = {ctrl_a_q, 3'h0} | `PDM_A_RSVD_MASK;
  wire [7:0] read_b = {3'h0, ctrl_b_q} | `PDM_B_RSVD_MASK;
  wire [7:0] read_mux = sel_a ? read_a : (sel_b ? read_b : 8'h00);
  // divider bits keep their value while the cpu runs from the subclock
  wire sub_div_lock = mode_q == PDM_SUBACT;
  wire [1:0] sub_div_next = sub_div_lock ? sub_div_field : reg_wdata[1:0];

  // reset pin: a change counts once the last two stages agree
  wire pin_agree = pin_sync_q[1] == pin_sync_q[2];
  wire pin_n_d = pin_agree ? pin_sync_q[2] : pin_n_q;

  // a source wakes only if enabled and the global mask is clear
  wire pdm_wake_t wake_ok = wake_req & wake_en & {4{~int_mask}};
  wire wake_sleep = |wake_ok;
  // retained external lines do not count in standby or watch
  wire wake_deep = wake_ok.timer_a | wake_ok.ext_base;
  wire wake_standby = wake_ok.ext_base;

  // settling target: base shifted by code, top bit forces the longest
  wire [2:0] wait_shift = wake_wait_sel[2] ? 3'h4 : {1'b0, wake_wait_sel[1:0]};
  wire [W-1:0] wait_target = W'(WAIT_BASE) << wait_shift;
  wire settle_done = settle_cnt_q == W'(wait_target - W'(1));

  wire pdm_mode_t resume_act = medium_speed_select ? PDM_ACT_MED : PDM_ACT_HI;
  wire in_active = mode_q == PDM_ACT_HI || mode_q == PDM_ACT_MED;
  wire ta_watch = timer_a_watch_select;
  wire ds_to_med = direct_transfer_enable && !standby_select && medium_speed_select && !low_speed_select;
  wire ds_to_hi = direct_transfer_enable && !standby_select && !medium_speed_select && !low_speed_select;
  wire ds_to_sub = direct_transfer_enable && standby_select && ta_watch && low_speed_select;
  wire ds_sub_up = direct_transfer_enable && standby_select && ta_watch && !low_speed_select;

  // active-mode sleep decode without a direct transfer
  pdm_mode_t act_sleep_dest;
  always_comb begin
    if (!standby_select) begin
      act_sleep_dest = PDM_SLEEP;
    end else if (ta_watch) begin
      act_sleep_dest = PDM_WATCH;
    end else if (!low_speed_select) begin
      act_sleep_dest = PDM_STANDBY;
    end else begin
      act_sleep_dest = mode_q;
    end
  end

  // next mode; only a sleep, a permitted wake, the end of the settling wait or the reset pin move it
  always_comb begin
    mode_d = mode_q;
    ack_d = 1'b0;
    case (mode_q)
      PDM_ACT_HI: begin
        if (sleep_exec) begin
          if (ds_to_med) begin
            mode_d = PDM_ACT_MED;
          end else if (ds_to_sub) begin
            mode_d = PDM_SUBACT;
          end else begin
            mode_d = act_sleep_dest;
          end
        end
      end
      PDM_ACT_MED: begin
        if (sleep_exec) begin
          if (ds_to_hi) begin
            mode_d = PDM_ACT_HI;
          end else if (ds_to_sub) begin
            mode_d = PDM_SUBACT;
          end else begin
            mode_d = act_sleep_dest;
          end
        end
      end
      PDM_SUBACT: begin
        if (sleep_exec) begin
          if (ds_sub_up) begin
            // system oscillator was off, so the wait applies before speeding up
            mode_d = PDM_SETTLE;
          end else if (!standby_select) begin
            mode_d = PDM_SUBSLEEP;
          end else if (ta_watch) begin
            mode_d = PDM_WATCH;
          end
        end
      end
      PDM_SLEEP: begin
        if (wake_sleep) begin
          mode_d = resume_act;
          ack_d = 1'b1;
        end
      end
      PDM_SUBSLEEP: begin
        if (wake_deep) begin
          mode_d = PDM_SUBACT;
          ack_d = 1'b1;
        end
      end
      PDM_STANDBY: begin
        if (wake_standby) begin
          mode_d = PDM_SETTLE;
        end
      end
      PDM_WATCH: begin
        if (wake_deep) begin
          if (low_speed_select) begin
            mode_d = PDM_SUBACT;
            ack_d = 1'b1;
          end else begin
            mode_d = PDM_SETTLE;
          end
        end
      end
      PDM_SETTLE: begin
        if (settle_done) begin
          mode_d = resume_act;
          ack_d = 1'b1;
        end
      end
      default: begin
        mode_d = PDM_ACT_HI;
      end
    endcase
    if (!pin_n_q) begin
      mode_d = PDM_ACT_HI;
      ack_d = 1'b0;
    end
  end

  // per-mode outputs, taken from the next mode so they line up with mode
  wire nx_halt = mode_d == PDM_SLEEP || mode_d == PDM_SUBSLEEP || mode_d == PDM_STANDBY
                 || mode_d == PDM_WATCH || mode_d == PDM_SETTLE;
  wire nx_sub = mode_d == PDM_SUBACT || mode_d == PDM_SUBSLEEP || mode_d == PDM_WATCH;
  wire nx_osc = mode_d == PDM_ACT_HI || mode_d == PDM_ACT_MED || mode_d == PDM_SLEEP
                || mode_d == PDM_SETTLE;
  wire nx_prun = mode_d == PDM_ACT_HI || mode_d == PDM_ACT_MED || mode_d == PDM_SLEEP;
  wire nx_pwm = mode_d == PDM_ACT_HI || mode_d == PDM_ACT_MED;
  wire nx_capt = mode_d != PDM_STANDBY && mode_d != PDM_WATCH && mode_d != PDM_SETTLE;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_a_q <= 5'(`PDM_A_RESET >> 3);
      ctrl_b_q <= 5'(`PDM_B_RESET);
      rdata_q <= 8'h00;
    end else begin
      if (wr_a) begin
        ctrl_a_q <= reg_wdata[7:3];
      end
      if (wr_b) begin
        ctrl_b_q <= {reg_wdata[4:2], sub_div_next};
      end
      rdata_q <= reg_rd ? read_mux : 8'h00;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_sync_q <= 3'h7;
      pin_n_q <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], reset_in_n};
      pin_n_q <= pin_n_d;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= PDM_ACT_HI;
      settle_cnt_q <= '0;
    end else begin
      mode_q <= mode_d;
      // counts only while the oscillator settles, restarts on each entry
      settle_cnt_q <= (mode_q == PDM_SETTLE && mode_d == PDM_SETTLE) ? W'(settle_cnt_q + W'(1)) : '0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      halt_q <= 1'b0;
      rst_out_q <= 1'b1;
      clk_sub_q <= 1'b0;
      osc_q <= 1'b1;
      sdiv_q <= 2'h0;
      div4_q <= 1'b0;
      prun_q <= 1'b1;
      pwm_q <= 1'b1;
      capt_q <= 1'b1;
      ack_q <= 1'b0;
    end else begin
      halt_q <= nx_halt;
      rst_out_q <= !pin_n_d;
      clk_sub_q <= nx_sub;
      osc_q <= nx_osc;
      sdiv_q <= wr_b ? sub_div_next : sub_div_field;
      div4_q <= wr_b ? reg_wdata[`PDM_B_SAMPLE_RATE] : watch_sample_rate_sel;
      prun_q <= nx_prun;
      pwm_q <= nx_pwm;
      capt_q <= nx_capt;
      ack_q <= ack_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign mode = mode_q;
  assign cpu_halt = halt_q;
  assign cpu_reset = rst_out_q;
  assign cpu_clk_sub = clk_sub_q;
  assign sys_osc_en = osc_q;
  // 00 -> /8, 01 -> /4, 1x -> /2 of the watch clock
  assign sub_clock_div = sdiv_q;
  assign watch_sample_div4 = div4_q;
  assign periph_run = prun_q;
  assign pwm_run = pwm_q;
  assign ext_irq_capture = capt_q;
  assign wake_ack = ack_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  AST_SLEEP_ENTRY: assert property (
    pin_n_q && mode_q == PDM_ACT_HI && sleep_exec && !direct_transfer_enable && !standby_select
    |=> mode_q == PDM_SLEEP && cpu_halt && periph_run && !pwm_run)
    else $error("sleep not entered from active");
  AST_WATCH_ENTRY: assert property (
    pin_n_q && in_active && sleep_exec && !direct_transfer_enable && standby_select && ta_watch
    |=> mode_q == PDM_WATCH && cpu_clk_sub && !sys_osc_en)
    else $error("watch not entered");
  AST_STANDBY_ENTRY: assert property (
    pin_n_q && in_active && sleep_exec && !direct_transfer_enable && standby_select && !ta_watch && !low_speed_select
    |=> mode_q == PDM_STANDBY && !ext_irq_capture)
    else $error("standby not entered");
  AST_DIRECT_MED: assert property (
    pin_n_q && mode_q == PDM_ACT_HI && sleep_exec && ds_to_med |=> mode_q == PDM_ACT_MED && !cpu_halt)
    else $error("direct move to medium speed missed");
  AST_RSVD_READ: assert property (
    reg_rd && (sel_a || sel_b) |=> ($past(sel_a) ? reg_rdata[2:0] == 3'h7 : reg_rdata[7:5] == 3'h7))
    else $error("reserved bits not read as one");
  AST_SUBDIV_LOCK: assert property (
    mode_q == PDM_SUBACT && wr_b |=> $stable(sub_div_field))
    else $error("sub divider changed in subactive");
  AST_MASKED_NO_WAKE: assert property (
    mode_q == PDM_SLEEP && int_mask && pin_n_q && !sleep_exec |=> mode_q == PDM_SLEEP && !wake_ack)
    else $error("masked request ended sleep");
  AST_SLEEP_WAKE: assert property (
    mode_q == PDM_SLEEP && wake_sleep && pin_n_q
    |=> wake_ack && mode_q == (medium_speed_select ? PDM_ACT_MED : PDM_ACT_HI) ##1 !wake_ack)
    else $error("sleep wake-up wrong");
  AST_SETTLE_HOLD: assert property (
    mode_q == PDM_SETTLE && !settle_done && pin_n_q |=> mode_q == PDM_SETTLE && !wake_ack)
    else $error("settling wait cut short");
  AST_SETTLE_RANGE: assert property (
    mode_q == PDM_SETTLE |-> settle_cnt_q < wait_target)
    else $error("settling counter beyond target");
  AST_RESET_PIN: assert property (
    !pin_n_q |-> cpu_reset ##1 mode_q == PDM_ACT_HI)
    else $error("reset pin did not clear mode");

  COV_SLEEP_WAKE: cover property (mode_q == PDM_SLEEP ##1 mode_q != PDM_SLEEP && wake_ack);
  COV_SETTLE_DONE: cover property (mode_q == PDM_SETTLE && settle_done);
  COV_WATCH_TO_SUB: cover property (mode_q == PDM_WATCH ##1 mode_q == PDM_SUBACT);
  COV_DIRECT_SUB: cover property (mode_q == PDM_ACT_HI ##1 mode_q == PDM_SUBACT);

endmodule

// >>> shared/pdm_defs.svh
// register map, field positions, reset values and timing counts for power-down control
`ifndef PDM_DEFS_SVH
`define PDM_DEFS_SVH

`define PDM_ADDR_CTRL_A 16'hFFF0
`define PDM_ADDR_CTRL_B 16'hFFF1

// power_mode_ctrl_a fields
`define PDM_A_STANDBY_SEL 7
`define PDM_A_WAIT_SEL_HI 6
`define PDM_A_WAIT_SEL_LO 4
`define PDM_A_LOW_SPEED 3
`define PDM_A_RSVD_MASK 8'h07
`define PDM_A_RESET 8'h07

// power_mode_ctrl_b fields
`define PDM_B_SAMPLE_RATE 4
`define PDM_B_DIRECT 3
`define PDM_B_MEDIUM 2
`define PDM_B_SUB_DIV_HI 1
`define PDM_B_SUB_DIV_LO 0
`define PDM_B_RSVD_MASK 8'hE0
`define PDM_B_RESET 8'hE0

// shortest settling wait in system clock states
`define PDM_WAIT_BASE_STATES 8192
// settling wait software should aim at, in ms
`define PDM_WAIT_MIN_MS 10
`define PDM_WAIT_CNT_W 18

`endif

// >>> shared/pdm_pkg.sv
// types for the power-down mode controller
package pdm_pkg;

  // gray codes along active -> sleep/settle -> standby/watch -> subactive
  typedef enum logic [2:0] {
    PDM_ACT_HI = 3'h0,
    PDM_ACT_MED = 3'h1,
    PDM_SLEEP = 3'h3,
    PDM_SETTLE = 3'h2,
    PDM_STANDBY = 3'h6,
    PDM_WATCH = 3'h7,
    PDM_SUBACT = 3'h5,
    PDM_SUBSLEEP = 3'h4
  } pdm_mode_t;

  // interrupt classes that can end a power-down mode
  typedef struct packed {
    logic timer_a;   // timer A
    logic ext_base;  // irq0 and wake-up pins, live in every mode
    logic ext_other; // irq1..4, only retained in standby/watch
    logic periph;    // timers b/c/f, serial, converter
  } pdm_wake_t;

endpackage
